// file: hdl/alpm_defines.svh
`ifndef ALPM_DEFINES_SVH
`define ALPM_DEFINES_SVH

// ****************
// timing
// ****************
`define ALPM_CLK_NS 100
`define ALPM_MS_NS 1000000
`define ALPM_US_NS 1000
`define ALPM_MS_CYCLES (`ALPM_MS_NS / `ALPM_CLK_NS)
`define ALPM_US_CYCLES (`ALPM_US_NS / `ALPM_CLK_NS)
`define ALPM_OVL_MS_PER_GAIN 10
`define ALPM_OVS_NUM 12
`define ALPM_OVS_DEN 10

// ****************
// register offsets
// ****************
`define ALPM_OFS_CTRL 8'h00
`define ALPM_OFS_FWD_LIMIT 8'h04
`define ALPM_OFS_REV_LIMIT 8'h08
`define ALPM_OFS_OVL_GAIN 8'h0C
`define ALPM_OFS_STALL_TIME 8'h10
`define ALPM_OFS_OVS_SET 8'h14
`define ALPM_OFS_MAX_SPEED 8'h18
`define ALPM_OFS_DIFILT0 8'h1C
`define ALPM_OFS_PROBE1_FILT 8'h30
`define ALPM_OFS_PROBE2_FILT 8'h34
`define ALPM_OFS_STATUS 8'h38

// ****************
// field positions
// ****************
`define ALPM_CTRL_LIM_LSB 0
`define ALPM_CTRL_LIM_MSB 1
`define ALPM_CTRL_OVL_MASK 2
`define ALPM_CTRL_STALL_EN 3
`define ALPM_CTRL_RUN_EN 4
`define ALPM_CTRL_OVS_CUSTOM 5
`define ALPM_CTRL_DI4_PROBE 6
`define ALPM_CTRL_DI5_PROBE 7
`define ALPM_ST_FWD 0
`define ALPM_ST_REV 1
`define ALPM_ST_STOP 2
`define ALPM_ST_OVL 3
`define ALPM_ST_STALL 4
`define ALPM_ST_OVS 5
`define ALPM_ST_RUN 6
`define ALPM_ST_HOMED 7
`define ALPM_ST_DI_LSB 8
`define ALPM_ST_DI_MSB 12

// ****************
// reset values
// ****************
`define ALPM_RST_CTRL 8'h18
`define ALPM_RST_FWD_LIMIT 32'h7FFFFFFF
`define ALPM_RST_REV_LIMIT 32'h80000000
`define ALPM_RST_OVL_GAIN 16'h0064
`define ALPM_RST_STALL_TIME 16'h00C8
`define ALPM_RST_OVS_SET 16'h0000
`define ALPM_RST_MAX_SPEED 16'h1770
`define ALPM_RST_DIFILT 16'h01F4
`define ALPM_RST_PROBE_FILT 16'h0064

`endif

// file: hdl/alpm_pkg.sv
package alpm_pkg;
    typedef logic signed [31:0] alpm_pos_t;
    typedef logic signed [15:0] alpm_spd_t;
    typedef logic [31:0] alpm_word_t;
    typedef logic [15:0] alpm_ftime_t;
    typedef enum logic [1:0] {
        ALPM_LIM_OFF = 2'h0,
        ALPM_LIM_ON = 2'h1,
        ALPM_LIM_HOMED = 2'h2
    } alpm_lim_e;
endpackage

// file: hdl/alpm_filt_if.sv
`timescale 1ns/1ps
interface alpm_filt_if;
    import alpm_pkg::*;
    logic raw;
    logic tick;
    alpm_ftime_t ftime;
    logic qual;
    modport filt (input raw, input tick, input ftime, output qual);
    modport top (output raw, output tick, output ftime, input qual);
endinterface

// file: hdl/alpm_di_filter.sv
`timescale 1ns/1ps
module alpm_di_filter (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    alpm_filt_if.filt f
);
    import alpm_pkg::*;
    alpm_ftime_t cnt_r;
    alpm_ftime_t cnt_nxt;
    alpm_ftime_t inc;
    logic qual_r;
    logic qual_nxt;

    // a level returning to the qualified value restarts the hold count
    always_comb begin
        inc = cnt_r + 16'h0001;
        cnt_nxt = cnt_r;
        qual_nxt = qual_r;
        if (f.raw == qual_r) begin
            cnt_nxt = 16'h0000;
        end else if (f.ftime == 16'h0000) begin
            qual_nxt = f.raw;
            cnt_nxt = 16'h0000;
        end else if (f.tick) begin
            if (inc >= f.ftime) begin
                qual_nxt = f.raw;
                cnt_nxt = 16'h0000;
            end else begin
                cnt_nxt = inc;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= 16'h0000;
            qual_r <= 1'b0;
        end else if (i_ce) begin
            cnt_r <= cnt_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign f.qual = qual_r;
endmodule

// file: hdl/alpm_axis_monitor.sv
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "alpm_defines.svh"
// Contract
// - setting zero disables limit comparison
// - setting one arms limits from power-on
// - above forward limit warns and stops
// - below reverse limit warns and stops
// - setting two arms only after homing
// - overload report time scales with gain
// - overload mask one suppresses overload fault
// - stall beyond threshold time reports fault
// - stall monitor enabled by default, disableable
// - overspeed above 1.2x max or setting
// - runaway enable zero suppresses runaway fault
// - five inputs, four and five fast
// - regular inputs use per-input filter time
// - probe inputs use probe filter time
// - fast inputs handle up to 4 kHz
module alpm_axis_monitor #(
    parameter int P_MS_CYCLES = `ALPM_MS_CYCLES,
    parameter int P_US_CYCLES = `ALPM_US_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire alpm_pkg::alpm_pos_t i_abs_pos,
    input wire logic i_homing_done,
    input wire alpm_pkg::alpm_spd_t i_speed,
    input wire logic i_overload_cond,
    input wire logic i_stalled,
    input wire logic i_runaway_cond,
    input wire logic [4:0] i_di,
    output logic o_fwd_overtravel_warning,
    output logic o_rev_overtravel_warning,
    output logic o_stop_req,
    output logic o_motor_overload_fault,
    output logic o_stall_overtemp_fault,
    output logic o_overspeed_fault,
    output logic o_runaway_fault,
    output logic [4:0] o_di_qual
);
    import alpm_pkg::*;

    // ****************
    // elaboration checks
    // ****************
    if (P_MS_CYCLES < 1 || P_MS_CYCLES > 16384) begin : g_chk_ms
        $error("P_MS_CYCLES out of range 1..16384");
    end
    if (P_US_CYCLES < 1 || P_US_CYCLES > 16) begin : g_chk_us
        $error("P_US_CYCLES out of range 1..16");
    end

    localparam logic [13:0] LP_MS_LAST = 14'(P_MS_CYCLES - 1);
    localparam logic [3:0] LP_US_LAST = 4'(P_US_CYCLES - 1);
    localparam logic [23:0] LP_OVL_MUL = 24'(`ALPM_OVL_MS_PER_GAIN);
    localparam logic [23:0] LP_OVS_NUM = 24'(`ALPM_OVS_NUM);
    localparam logic [23:0] LP_OVS_DEN = 24'(`ALPM_OVS_DEN);

    // ****************
    // configuration registers
    // ****************
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    alpm_pos_t fwd_r;
    alpm_pos_t fwd_nxt;
    alpm_pos_t rev_r;
    alpm_pos_t rev_nxt;
    logic [15:0] gain_r;
    logic [15:0] gain_nxt;
    logic [15:0] stall_t_r;
    logic [15:0] stall_t_nxt;
    logic [15:0] ovs_set_r;
    logic [15:0] ovs_set_nxt;
    logic [15:0] maxspd_r;
    logic [15:0] maxspd_nxt;
    alpm_ftime_t difilt_r [5];
    alpm_ftime_t difilt_nxt [5];
    alpm_ftime_t probe_r [2];
    alpm_ftime_t probe_nxt [2];

    always_comb begin
        ctrl_nxt = ctrl_r;
        fwd_nxt = fwd_r;
        rev_nxt = rev_r;
        gain_nxt = gain_r;
        stall_t_nxt = stall_t_r;
        ovs_set_nxt = ovs_set_r;
        maxspd_nxt = maxspd_r;
        difilt_nxt = difilt_r;
        probe_nxt = probe_r;
        if (i_wr) begin
            case (i_addr)
                `ALPM_OFS_CTRL: ctrl_nxt = i_wdata[7:0];
                `ALPM_OFS_FWD_LIMIT: fwd_nxt = i_wdata;
                `ALPM_OFS_REV_LIMIT: rev_nxt = i_wdata;
                `ALPM_OFS_OVL_GAIN: gain_nxt = i_wdata[15:0];
                `ALPM_OFS_STALL_TIME: stall_t_nxt = i_wdata[15:0];
                `ALPM_OFS_OVS_SET: ovs_set_nxt = i_wdata[15:0];
                `ALPM_OFS_MAX_SPEED: maxspd_nxt = i_wdata[15:0];
                `ALPM_OFS_PROBE1_FILT: probe_nxt[0] = i_wdata[15:0];
                `ALPM_OFS_PROBE2_FILT: probe_nxt[1] = i_wdata[15:0];
                default: ;
            endcase
            for (int k = 0; k < 5; k++) begin
                if (i_addr == 8'(`ALPM_OFS_DIFILT0 + 4 * k)) begin
                    difilt_nxt[k] = i_wdata[15:0];
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= `ALPM_RST_CTRL;
            fwd_r <= `ALPM_RST_FWD_LIMIT;
            rev_r <= `ALPM_RST_REV_LIMIT;
            gain_r <= `ALPM_RST_OVL_GAIN;
            stall_t_r <= `ALPM_RST_STALL_TIME;
            ovs_set_r <= `ALPM_RST_OVS_SET;
            maxspd_r <= `ALPM_RST_MAX_SPEED;
            for (int k = 0; k < 5; k++) begin
                difilt_r[k] <= `ALPM_RST_DIFILT;
            end
            for (int k = 0; k < 2; k++) begin
                probe_r[k] <= `ALPM_RST_PROBE_FILT;
            end
        end else if (i_ce) begin
            ctrl_r <= ctrl_nxt;
            fwd_r <= fwd_nxt;
            rev_r <= rev_nxt;
            gain_r <= gain_nxt;
            stall_t_r <= stall_t_nxt;
            ovs_set_r <= ovs_set_nxt;
            maxspd_r <= maxspd_nxt;
            difilt_r <= difilt_nxt;
            probe_r <= probe_nxt;
        end
    end

    // ****************
    // time bases and input synchroniser
    // ****************
    logic [13:0] ms_cnt_r;
    logic [13:0] ms_cnt_nxt;
    logic ms_tick_r;
    logic ms_tick_nxt;
    logic [3:0] us_cnt_r;
    logic [3:0] us_cnt_nxt;
    logic us_tick_r;
    logic us_tick_nxt;
    logic [4:0] di_s1_r;
    logic [4:0] di_s2_r;

    always_comb begin
        ms_tick_nxt = (ms_cnt_r == LP_MS_LAST);
        ms_cnt_nxt = ms_tick_nxt ? 14'h0000 : ms_cnt_r + 14'h0001;
        us_tick_nxt = (us_cnt_r == LP_US_LAST);
        us_cnt_nxt = us_tick_nxt ? 4'h0 : us_cnt_r + 4'h1;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ms_cnt_r <= 14'h0000;
            ms_tick_r <= 1'b0;
            us_cnt_r <= 4'h0;
            us_tick_r <= 1'b0;
            di_s1_r <= 5'h00;
            di_s2_r <= 5'h00;
        end else if (i_ce) begin
            ms_cnt_r <= ms_cnt_nxt;
            ms_tick_r <= ms_tick_nxt;
            us_cnt_r <= us_cnt_nxt;
            us_tick_r <= us_tick_nxt;
            di_s1_r <= i_di;
            di_s2_r <= di_s1_r;
        end
    end

    // ****************
    // input filters
    // ****************
    // microsecond resolution keeps a 125 us half period of a 4 kHz
    // signal well resolved on the fast inputs
    alpm_filt_if fif [5] ();
    logic [4:0] qual_w;

    for (genvar g = 0; g < 5; g++) begin : g_filt
        logic use_probe;
        if (g == 3) begin : g_p1
            assign use_probe = ctrl_r[`ALPM_CTRL_DI4_PROBE];
        end else if (g == 4) begin : g_p2
            assign use_probe = ctrl_r[`ALPM_CTRL_DI5_PROBE];
        end else begin : g_np
            assign use_probe = 1'b0;
        end
        assign fif[g].raw = di_s2_r[g];
        assign fif[g].tick = us_tick_r;
        assign fif[g].ftime = use_probe ? probe_r[g - 3 < 0 ? 0 : g - 3]
                                        : difilt_r[g];
        assign qual_w[g] = fif[g].qual;
        alpm_di_filter u_filt (
            .i_sys_clk(i_sys_clk),
            .i_rstn(i_rstn),
            .i_ce(i_ce),
            .f(fif[g].filt)
        );
    end

    assign o_di_qual = qual_w;

    // ****************
    // limit and motor monitors
    // ****************
    logic homed_r;
    logic homed_nxt;
    logic fwd_w_r;
    logic fwd_w_nxt;
    logic rev_w_r;
    logic rev_w_nxt;
    logic stop_r;
    logic stop_nxt;
    logic [23:0] ovl_cnt_r;
    logic [23:0] ovl_cnt_nxt;
    logic [15:0] stall_cnt_r;
    logic [15:0] stall_cnt_nxt;
    logic ovl_f_r;
    logic ovl_f_nxt;
    logic stall_f_r;
    logic stall_f_nxt;
    logic ovs_f_r;
    logic ovs_f_nxt;
    logic run_f_r;
    logic run_f_nxt;
    alpm_lim_e lim_sel;
    logic armed;
    logic st_clr;
    logic [23:0] ovl_thr;
    logic [16:0] spd_abs;
    logic [23:0] spd_lhs;
    logic [23:0] spd_rhs;
    logic ovs_hit;

    always_comb begin
        lim_sel = alpm_lim_e'(ctrl_r[`ALPM_CTRL_LIM_MSB:`ALPM_CTRL_LIM_LSB]);
        st_clr = i_wr && (i_addr == `ALPM_OFS_STATUS);
        homed_nxt = homed_r | i_homing_done;
        armed = 1'b0;
        if (lim_sel == ALPM_LIM_ON) begin
            armed = 1'b1;
        end else if (lim_sel == ALPM_LIM_HOMED) begin
            armed = homed_r;
        end
        fwd_w_nxt = armed && (i_abs_pos > fwd_r);
        rev_w_nxt = armed && (i_abs_pos < rev_r);
        stop_nxt = fwd_w_nxt | rev_w_nxt;

        // the heat count restarts once the motor is back below rated load
        ovl_thr = {8'h00, gain_r} * LP_OVL_MUL;
        ovl_cnt_nxt = ovl_cnt_r;
        if (!i_overload_cond) begin
            ovl_cnt_nxt = 24'h000000;
        end else if (ms_tick_r && ovl_cnt_r != 24'hFFFFFF) begin
            ovl_cnt_nxt = ovl_cnt_r + 24'h000001;
        end
        ovl_f_nxt = 1'b0;
        if (!ctrl_r[`ALPM_CTRL_OVL_MASK]) begin
            ovl_f_nxt = (i_overload_cond && ovl_cnt_r >= ovl_thr)
                      | (ovl_f_r & ~(st_clr & i_wdata[`ALPM_ST_OVL]));
        end

        stall_cnt_nxt = stall_cnt_r;
        if (!i_stalled || !ctrl_r[`ALPM_CTRL_STALL_EN]) begin
            stall_cnt_nxt = 16'h0000;
        end else if (ms_tick_r && stall_cnt_r != 16'hFFFF) begin
            stall_cnt_nxt = stall_cnt_r + 16'h0001;
        end
        stall_f_nxt = 1'b0;
        if (ctrl_r[`ALPM_CTRL_STALL_EN]) begin
            stall_f_nxt = (i_stalled && stall_cnt_r > stall_t_r)
                        | (stall_f_r & ~(st_clr & i_wdata[`ALPM_ST_STALL]));
        end

        // scaled compare avoids a divider for the 1.2x default
        spd_abs = i_speed[15] ? 17'(-{i_speed[15], i_speed})
                              : {1'b0, i_speed};
        if (ctrl_r[`ALPM_CTRL_OVS_CUSTOM]) begin
            spd_lhs = {7'h00, spd_abs};
            spd_rhs = {8'h00, ovs_set_r};
        end else begin
            spd_lhs = {7'h00, spd_abs} * LP_OVS_DEN;
            spd_rhs = {8'h00, maxspd_r} * LP_OVS_NUM;
        end
        ovs_hit = spd_lhs > spd_rhs;
        ovs_f_nxt = ovs_hit | (ovs_f_r & ~(st_clr & i_wdata[`ALPM_ST_OVS]));

        run_f_nxt = 1'b0;
        if (ctrl_r[`ALPM_CTRL_RUN_EN]) begin
            run_f_nxt = i_runaway_cond
                      | (run_f_r & ~(st_clr & i_wdata[`ALPM_ST_RUN]));
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            homed_r <= 1'b0;
            fwd_w_r <= 1'b0;
            rev_w_r <= 1'b0;
            stop_r <= 1'b0;
            ovl_cnt_r <= 24'h000000;
            stall_cnt_r <= 16'h0000;
            ovl_f_r <= 1'b0;
            stall_f_r <= 1'b0;
            ovs_f_r <= 1'b0;
            run_f_r <= 1'b0;
        end else if (i_ce) begin
            homed_r <= homed_nxt;
            fwd_w_r <= fwd_w_nxt;
            rev_w_r <= rev_w_nxt;
            stop_r <= stop_nxt;
            ovl_cnt_r <= ovl_cnt_nxt;
            stall_cnt_r <= stall_cnt_nxt;
            ovl_f_r <= ovl_f_nxt;
            stall_f_r <= stall_f_nxt;
            ovs_f_r <= ovs_f_nxt;
            run_f_r <= run_f_nxt;
        end
    end

    assign o_fwd_overtravel_warning = fwd_w_r;
    assign o_rev_overtravel_warning = rev_w_r;
    assign o_stop_req = stop_r;
    assign o_motor_overload_fault = ovl_f_r;
    assign o_stall_overtemp_fault = stall_f_r;
    assign o_overspeed_fault = ovs_f_r;
    assign o_runaway_fault = run_f_r;

    // ****************
    // read port
    // ****************
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    alpm_word_t status_w;

    always_comb begin
        status_w = 32'h00000000;
        status_w[`ALPM_ST_FWD] = fwd_w_r;
        status_w[`ALPM_ST_REV] = rev_w_r;
        status_w[`ALPM_ST_STOP] = stop_r;
        status_w[`ALPM_ST_OVL] = ovl_f_r;
        status_w[`ALPM_ST_STALL] = stall_f_r;
        status_w[`ALPM_ST_OVS] = ovs_f_r;
        status_w[`ALPM_ST_RUN] = run_f_r;
        status_w[`ALPM_ST_HOMED] = homed_r;
        status_w[`ALPM_ST_DI_MSB:`ALPM_ST_DI_LSB] = qual_w;
        rdata_nxt = 32'h00000000;
        if (i_rd) begin
            case (i_addr)
                `ALPM_OFS_CTRL: rdata_nxt = {24'h000000, ctrl_r};
                `ALPM_OFS_FWD_LIMIT: rdata_nxt = fwd_r;
                `ALPM_OFS_REV_LIMIT: rdata_nxt = rev_r;
                `ALPM_OFS_OVL_GAIN: rdata_nxt = {16'h0000, gain_r};
                `ALPM_OFS_STALL_TIME: rdata_nxt = {16'h0000, stall_t_r};
                `ALPM_OFS_OVS_SET: rdata_nxt = {16'h0000, ovs_set_r};
                `ALPM_OFS_MAX_SPEED: rdata_nxt = {16'h0000, maxspd_r};
                `ALPM_OFS_PROBE1_FILT: rdata_nxt = {16'h0000, probe_r[0]};
                `ALPM_OFS_PROBE2_FILT: rdata_nxt = {16'h0000, probe_r[1]};
                `ALPM_OFS_STATUS: rdata_nxt = status_w;
                default: ;
            endcase
            for (int k = 0; k < 5; k++) begin
                if (i_addr == 8'(`ALPM_OFS_DIFILT0 + 4 * k)) begin
                    rdata_nxt = {16'h0000, difilt_r[k]};
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_r <= 32'h00000000;
        end else if (i_ce) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;
endmodule

// file: verif/alpm_chk.sv
`timescale 1ns/1ps
`include "alpm_defines.svh"
module alpm_chk (
    input logic i_sys_clk,
    input logic i_rstn,
    input logic i_ce,
    input logic [7:0] i_addr,
    input logic [31:0] i_wdata,
    input logic i_wr,
    input logic i_rd,
    input logic [31:0] o_rdata,
    input alpm_pkg::alpm_pos_t i_abs_pos,
    input logic i_homing_done,
    input alpm_pkg::alpm_spd_t i_speed,
    input logic i_runaway_cond,
    input logic o_fwd_overtravel_warning,
    input logic o_rev_overtravel_warning,
    input logic o_stop_req,
    input logic o_motor_overload_fault,
    input logic o_stall_overtemp_fault,
    input logic o_overspeed_fault,
    input logic o_runaway_fault
);
    import alpm_pkg::*;
    // ****************
    // shadow of settings
    // ****************
    logic [7:0] ctrl_r, ctrl_nxt;
    alpm_pos_t fwd_r, fwd_nxt, rev_r, rev_nxt;
    logic [15:0] max_r, max_nxt;
    logic homed_r, homed_nxt, armed;
    int spd_abs;
    always_comb begin
        ctrl_nxt = ctrl_r;
        fwd_nxt = fwd_r;
        rev_nxt = rev_r;
        max_nxt = max_r;
        homed_nxt = homed_r | (i_ce & i_homing_done);
        if (i_ce && i_wr) begin
            case (i_addr)
                `ALPM_OFS_CTRL: ctrl_nxt = i_wdata[7:0];
                `ALPM_OFS_FWD_LIMIT: fwd_nxt = i_wdata;
                `ALPM_OFS_REV_LIMIT: rev_nxt = i_wdata;
                `ALPM_OFS_MAX_SPEED: max_nxt = i_wdata[15:0];
                default: ;
            endcase
        end
        armed = (ctrl_r[1:0] == 2'h1) || (ctrl_r[1:0] == 2'h2 && homed_r);
        spd_abs = (i_speed < 0) ? -int'(i_speed) : int'(i_speed);
    end
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= `ALPM_RST_CTRL;
            fwd_r <= `ALPM_RST_FWD_LIMIT;
            rev_r <= `ALPM_RST_REV_LIMIT;
            max_r <= `ALPM_RST_MAX_SPEED;
            homed_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            fwd_r <= fwd_nxt;
            rev_r <= rev_nxt;
            max_r <= max_nxt;
            homed_r <= homed_nxt;
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    property p_fwd;
        i_ce && armed |=>
            o_fwd_overtravel_warning == $past(i_abs_pos > fwd_r);
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("forward warning wrong");
    property p_rev;
        i_ce && armed |=>
            o_rev_overtravel_warning == $past(i_abs_pos < rev_r);
    endproperty
    a_rev: assert property (p_rev)
        else $error("reverse warning wrong");
    property p_off;
        i_ce && !armed |=>
            !o_fwd_overtravel_warning && !o_rev_overtravel_warning;
    endproperty
    a_off: assert property (p_off)
        else $error("warning while unarmed");
    property p_stop;
        o_stop_req == (o_fwd_overtravel_warning | o_rev_overtravel_warning);
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop request wrong");
    property p_ovl_mask;
        i_ce && ctrl_r[`ALPM_CTRL_OVL_MASK] |=> !o_motor_overload_fault;
    endproperty
    a_ovl_mask: assert property (p_ovl_mask)
        else $error("overload fault while masked");
    property p_stall_off;
        i_ce && !ctrl_r[`ALPM_CTRL_STALL_EN] |=> !o_stall_overtemp_fault;
    endproperty
    a_stall_off: assert property (p_stall_off)
        else $error("stall fault while disabled");
    property p_run;
        i_ce |=> o_runaway_fault == ($past(ctrl_r[`ALPM_CTRL_RUN_EN]) &&
            ($past(i_runaway_cond) || $past(o_runaway_fault) &&
            !$past(i_wr && i_addr == `ALPM_OFS_STATUS &&
            i_wdata[`ALPM_ST_RUN])));
    endproperty
    a_run: assert property (p_run)
        else $error("runaway fault wrong");
    property p_ovs;
        i_ce && !ctrl_r[`ALPM_CTRL_OVS_CUSTOM] &&
            spd_abs * 10 > int'(max_r) * 12 |=> o_overspeed_fault;
    endproperty
    a_ovs: assert property (p_ovs)
        else $error("overspeed not flagged");
    property p_rdata;
        !i_rd ##1 !i_rd |-> o_rdata == 32'h0;
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("stray read data");
endmodule
bind alpm_axis_monitor alpm_chk chk_u (.i_sys_clk, .i_rstn, .i_ce,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_abs_pos, .i_homing_done,
    .i_speed, .i_runaway_cond, .o_fwd_overtravel_warning,
    .o_rev_overtravel_warning, .o_stop_req, .o_motor_overload_fault,
    .o_stall_overtemp_fault, .o_overspeed_fault, .o_runaway_fault);

// file: verif/alpm_plant_model.sv
`timescale 1ns/1ps
module alpm_plant_model (
    input logic i_sys_clk,
    input alpm_pkg::alpm_pos_t i_pos_tgt,
    input alpm_pkg::alpm_spd_t i_spd_tgt,
    input logic [4:0] i_di_tgt,
    input logic i_home_req,
    output alpm_pkg::alpm_pos_t o_abs_pos,
    output alpm_pkg::alpm_spd_t o_speed,
    output logic [4:0] o_di,
    output logic o_homing_done
);
    // ****************
    // feedback and pins
    // ****************
    always @(posedge i_sys_clk) begin
        o_abs_pos <= i_pos_tgt;
        o_speed <= i_spd_tgt;
        o_di <= i_di_tgt;
        o_homing_done <= i_home_req;
    end
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
`include "alpm_defines.svh"
module tb;
    import alpm_pkg::*;
    logic i_sys_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, home_req = 0;
    logic ovl = 0, stl = 0, run = 0, homed;
    logic fwd, rev, stop, f_ovl, f_stl, f_ovs, f_run;
    logic [7:0] i_addr = '0;
    logic [31:0] i_wdata = '0, o_rdata;
    alpm_pos_t pos_tgt = '0, abs_pos;
    alpm_spd_t spd_tgt = '0, speed;
    logic [4:0] di_tgt = '0, di, qual;
    wire logic [31:0] lim = {29'h0, stop, rev, fwd};
    int fails = 0, checks = 0;
    logic [7:0] ofs [12] = '{`ALPM_OFS_CTRL, `ALPM_OFS_FWD_LIMIT,
        `ALPM_OFS_REV_LIMIT, `ALPM_OFS_OVL_GAIN, `ALPM_OFS_STALL_TIME,
        `ALPM_OFS_OVS_SET, `ALPM_OFS_MAX_SPEED, `ALPM_OFS_DIFILT0,
        `ALPM_OFS_PROBE1_FILT, `ALPM_OFS_PROBE2_FILT, `ALPM_OFS_STATUS,
        8'h3C};
    logic [31:0] rv [12] = '{`ALPM_RST_CTRL, `ALPM_RST_FWD_LIMIT,
        `ALPM_RST_REV_LIMIT, `ALPM_RST_OVL_GAIN, `ALPM_RST_STALL_TIME,
        `ALPM_RST_OVS_SET, `ALPM_RST_MAX_SPEED, `ALPM_RST_DIFILT,
        `ALPM_RST_PROBE_FILT, `ALPM_RST_PROBE_FILT, 32'h0, 32'h0};
    always #50 i_sys_clk = ~i_sys_clk;
    alpm_plant_model pm_u (.i_sys_clk(i_sys_clk), .i_pos_tgt(pos_tgt),
        .i_spd_tgt(spd_tgt), .i_di_tgt(di_tgt), .i_home_req(home_req),
        .o_abs_pos(abs_pos), .o_speed(speed), .o_di(di),
        .o_homing_done(homed));
    // short ms and us ticks keep the run brief
    alpm_axis_monitor #(.P_MS_CYCLES(4), .P_US_CYCLES(2)) dut_u (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(1'b1),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_abs_pos(abs_pos), .i_homing_done(homed),
        .i_speed(speed), .i_overload_cond(ovl), .i_stalled(stl),
        .i_runaway_cond(run), .i_di(di), .o_fwd_overtravel_warning(fwd),
        .o_rev_overtravel_warning(rev), .o_stop_req(stop),
        .o_motor_overload_fault(f_ovl), .o_stall_overtemp_fault(f_stl),
        .o_overspeed_fault(f_ovs), .o_runaway_fault(f_run),
        .o_di_qual(qual));
    // ****************
    // tasks
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        for (int k = 0; k < 12; k++) rd(ofs[k], rv[k]);
        wr(`ALPM_OFS_FWD_LIMIT, 32'd1000);
        wr(`ALPM_OFS_REV_LIMIT, -32'sd1000);
        @(posedge i_sys_clk) pos_tgt <= 32'sd2000;
        cyc(4);
        check(lim, 32'h0);
        wr(`ALPM_OFS_CTRL, 32'h19);
        cyc(3);
        check(lim, 32'h5);
        @(posedge i_sys_clk) pos_tgt <= 32'sd1000;
        cyc(3);
        check(lim, 32'h0);
        @(posedge i_sys_clk) pos_tgt <= -32'sd1001;
        cyc(3);
        check(lim, 32'h6);
        @(posedge i_sys_clk) pos_tgt <= -32'sd1000;
        cyc(3);
        check(lim, 32'h0);
        @(posedge i_sys_clk) pos_tgt <= 32'sd2000;
        wr(`ALPM_OFS_CTRL, 32'h1A);
        cyc(4);
        check(lim, 32'h0);
        @(posedge i_sys_clk) home_req <= 1'b1;
        @(posedge i_sys_clk) home_req <= 1'b0;
        cyc(4);
        check(lim, 32'h5);
        rd(`ALPM_OFS_STATUS, 32'h85);
        @(posedge i_sys_clk) pos_tgt <= 32'sd0;
        wr(`ALPM_OFS_CTRL, 32'h18);
        wr(`ALPM_OFS_OVL_GAIN, 32'h1);
        @(posedge i_sys_clk) ovl <= 1'b1;
        cyc(30);
        check(f_ovl, 32'h0);
        cyc(30);
        check(f_ovl, 32'h1);
        wr(`ALPM_OFS_CTRL, 32'h1C);
        cyc(60);
        check(f_ovl, 32'h0);
        @(posedge i_sys_clk) ovl <= 1'b0;
        wr(`ALPM_OFS_STALL_TIME, 32'h2);
        @(posedge i_sys_clk) stl <= 1'b1;
        cyc(5);
        check(f_stl, 32'h0);
        cyc(30);
        check(f_stl, 32'h1);
        wr(`ALPM_OFS_CTRL, 32'h10);
        cyc(3);
        check(f_stl, 32'h0);
        @(posedge i_sys_clk) stl <= 1'b0;
        @(posedge i_sys_clk) spd_tgt <= 16'sd7200;
        cyc(4);
        check(f_ovs, 32'h0);
        @(posedge i_sys_clk) spd_tgt <= 16'sd7201;
        cyc(4);
        check(f_ovs, 32'h1);
        @(posedge i_sys_clk) spd_tgt <= -16'sd100;
        wr(`ALPM_OFS_OVS_SET, 32'd100);
        wr(`ALPM_OFS_CTRL, 32'h38);
        wr(`ALPM_OFS_STATUS, 32'h20);
        cyc(3);
        check(f_ovs, 32'h0);
        @(posedge i_sys_clk) spd_tgt <= -16'sd101;
        cyc(4);
        check(f_ovs, 32'h1);
        @(posedge i_sys_clk) run <= 1'b1;
        cyc(3);
        check(f_run, 32'h1);
        wr(`ALPM_OFS_CTRL, 32'h28);
        cyc(3);
        check(f_run, 32'h0);
        @(posedge i_sys_clk) run <= 1'b0;
        wr(`ALPM_OFS_DIFILT0, 32'd5);
        @(posedge i_sys_clk) di_tgt <= 5'h01;
        repeat (4) @(posedge i_sys_clk);
        di_tgt <= 5'h00;
        cyc(30);
        check(qual, 32'h0);
        @(posedge i_sys_clk) di_tgt <= 5'h01;
        cyc(8);
        check(qual, 32'h0);
        cyc(20);
        check(qual, 32'h1);
        wr(8'h28, 32'd50);
        wr(`ALPM_OFS_PROBE1_FILT, 32'd3);
        wr(`ALPM_OFS_CTRL, 32'h68);
        @(posedge i_sys_clk) di_tgt <= 5'h09;
        cyc(20);
        check(qual, 32'h9);
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        fails++;
        tally_and_finish();
    end
endmodule
